// file: bench/ald_apb_host.sv
// APB host model standing in for the core's decoder and register file.
// Assumes a free running pclk; a slave that never answers sets hung.
`timescale 1ns/1ps
module ald_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic hung = 1'b0;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    hung = (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data is inverted so a slave cannot lean on a stale value.
    pwdata <= ~wd;
  endtask
endmodule

// file: bench/ald_datapath_sva.sv
// Checker of the datapath's timing and flag behaviour at its ports.
// Assumes it is bound to ald_datapath and sees only that module's ports.
`timescale 1ns/1ps
module ald_sva_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] status_flags,
  input wire logic busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_op_wr;
    pready && psel && penable && pwrite && paddr == 8'h00 && !busy;
  endsequence
  sequence s_word_op;
    s_op_wr ##0 (pwdata[4:0] == 5'h02 || pwdata[4:0] == 5'h07);
  endsequence
  sequence s_byte_op;
    s_op_wr ##0 (pwdata[4:0] <= 5'h11 && pwdata[4:0] != 5'h02 && pwdata[4:0] != 5'h07);
  endsequence
  sequence s_logic_op;
    s_op_wr ##0 (pwdata[4:0] inside {5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0E, 5'h0F, 5'h11});
  endsequence
  a_word_two_clk: assert property (s_word_op |=> busy ##1 !busy)
    else $error("word operation did not take two clocks");
  a_byte_one_clk: assert property (s_byte_op |=> !busy)
    else $error("byte operation raised busy");
  a_inc_keeps_c: assert property (s_op_wr ##0 pwdata[4:0] == 5'h10 |=> status_flags[0] == $past(status_flags[0]))
    else $error("increment changed carry");
  a_logic_keeps: assert property (s_logic_op |=> ($past(status_flags) & 8'hF1) == (status_flags & 8'hF1))
    else $error("logic operation changed an unlisted flag");
  a_logic_v_clear: assert property (s_logic_op |=> !status_flags[3])
    else $error("logic operation left overflow set");
  a_byte_keeps_s: assert property (s_byte_op |=> (status_flags & 8'hD0) == ($past(status_flags) & 8'hD0))
    else $error("byte operation changed sign flag");
  a_word_keeps_h: assert property (s_word_op |=> ##1 status_flags[5] == $past(status_flags[5], 2))
    else $error("word operation changed half carry");
  a_word_sign: assert property (s_word_op |=> ##1 status_flags[4] == (status_flags[2] ^ status_flags[3]))
    else $error("word operation sign flag wrong");
  // Flags may only move at a write edge or in the second word cycle.
  a_flags_idle: assert property (!busy && !(pready && pwrite) |=> $stable(status_flags))
    else $error("flags changed without an operation");
endmodule
bind ald_datapath ald_sva_chk ald_sva_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .status_flags(status_flags), .busy(busy));

// file: bench/tb.sv
// Self-checking bench of the 8-bit datapath driven through its APB port.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps
`include "ald_map.svh"
module tb;
  import ald_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, busy, err;
  logic [7:0] paddr, status_flags;
  logic [31:0] pwdata, prdata, rd;
  int mismatches = 0;
  int check_count = 0;
  initial begin
    forever #2 pclk = ~pclk;
  end
  ald_apb_host ald_apb_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ald_datapath ald_datapath_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_flags(status_flags), .busy(busy));
  task automatic end_of_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", what, e, s);
      mismatches++;
    end
  endtask
  task automatic cmp1(input string what, input logic e, input logic s);
    check_count++;
    if (s !== e) begin
      $display("wrong value %s expected %b seen %b", what, e, s);
      mismatches++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    ald_apb_host_inst.xfer(w, a, wd, rd, err);
    if (ald_apb_host_inst.hung) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic run_op(input ald_op_e op, input logic [7:0] d, s, hi, k, fin, ed, eh, ef);
    bus(1'b1, `ALD_OFF_DEST, 32'(d));
    bus(1'b1, `ALD_OFF_SRC, 32'(s));
    bus(1'b1, `ALD_OFF_HIGH, 32'(hi));
    bus(1'b1, `ALD_OFF_IMM, 32'(k));
    bus(1'b1, `ALD_OFF_FLAGS, 32'(fin));
    bus(1'b1, `ALD_OFF_CTRL, 32'(op));
    bus(1'b0, `ALD_OFF_CTRL, 32'h0000_0000);
    cmp1("busy bit", 1'b0, rd[8]);
    cmp8("last op", 8'(op), {3'b000, rd[4:0]});
    bus(1'b0, `ALD_OFF_DEST, 32'h0000_0000);
    cmp8("dest", ed, rd[7:0]);
    bus(1'b0, `ALD_OFF_HIGH, 32'h0000_0000);
    cmp8("high", eh, rd[7:0]);
    bus(1'b0, `ALD_OFF_FLAGS, 32'h0000_0000);
    cmp8("flags", ef, rd[7:0]);
    cmp8("flag port", ef, status_flags);
  endtask
  task automatic t_reset();
    bus(1'b0, `ALD_OFF_DEST, 32'h0000_0000);
    cmp8("dest reset", 8'h00, rd[7:0]);
    cmp8("flag port reset", 8'h00, status_flags);
  endtask
  task automatic t_arith();
    run_op(ALD_OP_ADD, 8'h7F, 8'h01, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h2C);
    run_op(ALD_OP_ADD_CARRY, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h23);
    run_op(ALD_OP_WORD_ADD_IMMEDIATE, 8'hFF, 8'h00, 8'h00, 8'h01, 8'hE0, 8'h00, 8'h01, 8'hE0);
    run_op(ALD_OP_WORD_ADD_IMMEDIATE, 8'hFF, 8'h00, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h00, 8'h03);
    run_op(ALD_OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h00, 8'h00, 8'h01, 8'h20, 8'hFF, 8'hFF, 8'h35);
    run_op(ALD_OP_SUB, 8'h10, 8'h20, 8'h00, 8'h00, 8'h10, 8'hF0, 8'h00, 8'h15);
    run_op(ALD_OP_SUBTRACT_CONSTANT, 8'h80, 8'h55, 8'h00, 8'h01, 8'h00, 8'h7F, 8'h00, 8'h28);
    run_op(ALD_OP_SUBTRACT_WITH_BORROW, 8'h05, 8'h05, 8'h00, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h25);
    run_op(ALD_OP_SUBTRACT_CONSTANT_WITH_BORROW, 8'h05, 8'h00, 8'h00, 8'h04, 8'h01, 8'h00, 8'h00, 8'h02);
    run_op(ALD_OP_TWOS_COMPLEMENT_FLIP, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h0D);
    run_op(ALD_OP_INCREMENT, 8'h7F, 8'h00, 8'h00, 8'h00, 8'h01, 8'h80, 8'h00, 8'h0D);
  endtask
  task automatic t_logic();
    run_op(ALD_OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h00, 8'h39, 8'h00, 8'h00, 8'h33);
    run_op(ALD_OP_AND_CONSTANT, 8'hC3, 8'h00, 8'h00, 8'h81, 8'h00, 8'h81, 8'h00, 8'h04);
    run_op(ALD_OP_OR, 8'h80, 8'h01, 8'h00, 8'h00, 8'h0B, 8'h81, 8'h00, 8'h05);
    run_op(ALD_OP_OR_CONSTANT, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02);
    run_op(ALD_OP_EXCLUSIVE_OR, 8'hAA, 8'hAA, 8'h00, 8'h00, 8'h21, 8'h00, 8'h00, 8'h23);
    run_op(ALD_OP_SET_BITS_MASKED, 8'h01, 8'h00, 8'h00, 8'h10, 8'h08, 8'h11, 8'h00, 8'h00);
    run_op(ALD_OP_CLEAR_BITS_MASKED, 8'hFF, 8'h00, 8'h00, 8'h0F, 8'h01, 8'hF0, 8'h00, 8'h05);
    run_op(ALD_OP_ZERO_SIGN_TEST, 8'h90, 8'h00, 8'h00, 8'h00, 8'h20, 8'h90, 8'h00, 8'h24);
  endtask
  task automatic t_unmapped();
    bus(1'b1, 8'h18, 32'h0000_00FF);
    cmp1("write error", 1'b1, err);
    bus(1'b0, 8'h18, 32'h0000_0000);
    cmp1("read error", 1'b1, err);
    cmp8("read data", 8'h00, rd[7:0]);
  endtask
  task automatic t_refused();
    bus(1'b1, `ALD_OFF_FLAGS, 32'h0000_0015);
    bus(1'b1, `ALD_OFF_CTRL, 32'h0000_001F);
    cmp1("unknown op error", 1'b0, err);
    bus(1'b0, `ALD_OFF_CTRL, 32'h0000_0000);
    cmp8("last op kept", 8'(ALD_OP_ZERO_SIGN_TEST), {3'b000, rd[4:0]});
    bus(1'b0, `ALD_OFF_DEST, 32'h0000_0000);
    cmp8("dest kept", 8'h90, rd[7:0]);
    cmp8("flags kept", 8'h15, status_flags);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_arith();
    t_logic();
    t_unmapped();
    t_refused();
    end_of_test();
  end
endmodule

// file: hw/ald_datapath.sv
// 8-bit arithmetic and logic datapath with its operand and flag registers behind an APB slave.
// Assumes one clock pclk, an asynchronous active-low reset and an APB master that holds each request.
// Functional notes
// - Add registers, optional carry, one clock, ZCNVH.
// - Word add constant to pair, two clocks, ZCNVS.
// - Word subtract constant from pair, two clocks.
// - Subtract register or constant, one clock, ZCNVH.
// - Subtract operand and carry, one clock, ZCNVH.
// - AND with register or constant, flags ZNV.
// - OR, exclusive OR, OR constant: ZNV only.
// - Negate as zero minus value, ZCNVH.
// - Set bits: OR with mask, ZNV.
// - Clear bits: AND with all-ones minus mask.
// - Increment by one, carry left untouched.
// - Test: AND with itself, value unchanged.
`timescale 1ns/1ps
`include "ald_map.svh"

module ald_datapath (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] status_flags,
  output logic busy
);
  import ald_pkg::*;

  ald_state_s s_q;
  ald_state_s s_d;

  // Sum with carry out and carry out of bit 3.
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] full;
    logic [4:0] nib;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {full[8], (nib > `ALD_NIBBLE_MAX), full[7:0]};
  endfunction

  // Borrow comes from a compare of the widened operands, so no sign tricks are needed.
  // Difference with borrow out and borrow out of bit 3.
  function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic bin);
    logic [8:0] need;
    logic [4:0] nib;
    logic [7:0] diff;
    need = {1'b0, b} + {8'h00, bin};
    nib = {1'b0, b[3:0]} + {4'h0, bin};
    diff = a - b - {7'h00, bin};
    return {(need > {1'b0, a}), (nib > {1'b0, a[3:0]}), diff};
  endfunction

  // Address decode is a priority chain; only one offset can match at a time.
  // Any other address is flagged as an error instead of being aliased.
  logic sel_ctrl;
  logic sel_dest;
  logic sel_src;
  logic sel_high;
  logic sel_imm;
  logic sel_flags;
  logic mapped;
  logic [31:0] rd_word;

  always_comb begin
    sel_ctrl = 1'b0;
    sel_dest = 1'b0;
    sel_src = 1'b0;
    sel_high = 1'b0;
    sel_imm = 1'b0;
    sel_flags = 1'b0;
    if (paddr == `ALD_OFF_CTRL) begin
      sel_ctrl = 1'b1;
    end else if (paddr == `ALD_OFF_DEST) begin
      sel_dest = 1'b1;
    end else if (paddr == `ALD_OFF_SRC) begin
      sel_src = 1'b1;
    end else if (paddr == `ALD_OFF_HIGH) begin
      sel_high = 1'b1;
    end else if (paddr == `ALD_OFF_IMM) begin
      sel_imm = 1'b1;
    end else if (paddr == `ALD_OFF_FLAGS) begin
      sel_flags = 1'b1;
    end
    mapped = sel_ctrl | sel_dest | sel_src | sel_high | sel_imm | sel_flags;
  end

  // Unused bits of a read word are zero, so software may compare whole words.
  always_comb begin
    rd_word = `ALD_RST_WORD;
    if (sel_ctrl) begin
      rd_word[`ALD_CTRL_OP_MSB:0] = s_q.op;
      rd_word[`ALD_CTRL_BUSY_BIT] = (s_q.st == ALD_ST_WORD_HI);
    end else if (sel_dest) begin
      rd_word[7:0] = s_q.dest;
    end else if (sel_src) begin
      rd_word[7:0] = s_q.src;
    end else if (sel_high) begin
      rd_word[7:0] = s_q.high;
    end else if (sel_imm) begin
      rd_word[7:0] = s_q.imm;
    end else if (sel_flags) begin
      rd_word[7:0] = s_q.sreg;
    end
  end

  // Operation decode and execution share one combinational pass over the state record.
  // The add8 and sub8 functions serve the byte add and subtract operations and the low byte of the word operations.
  logic wr_take;
  logic start;
  ald_op_e new_op;
  logic op_known;
  logic [9:0] ar;
  logic [7:0] res;
  logic [7:0] opnd;
  logic [7:0] hres;
  logic [15:0] word;
  logic c_in;

  always_comb begin
    s_d = s_q;
    res = s_q.dest;
    opnd = s_q.src;
    ar = 10'h000;
    hres = s_q.high;
    word = {s_q.high, s_q.dest};
    c_in = s_q.sreg[`ALD_FLAG_C];
    // Unknown codes are dropped without an error, so a newer program cannot stall the bus.
    // The last valid code stays readable in the control register.
    new_op = ald_op_e'(pwdata[`ALD_CTRL_OP_MSB:0]);
    op_known = 1'b1;
    case (new_op)
      ALD_OP_ADD, ALD_OP_ADD_CARRY, ALD_OP_WORD_ADD_IMMEDIATE, ALD_OP_SUB,
      ALD_OP_SUBTRACT_CONSTANT, ALD_OP_SUBTRACT_WITH_BORROW,
      ALD_OP_SUBTRACT_CONSTANT_WITH_BORROW, ALD_OP_WORD_SUBTRACT_IMMEDIATE,
      ALD_OP_AND, ALD_OP_AND_CONSTANT, ALD_OP_OR, ALD_OP_OR_CONSTANT,
      ALD_OP_EXCLUSIVE_OR, ALD_OP_TWOS_COMPLEMENT_FLIP, ALD_OP_SET_BITS_MASKED,
      ALD_OP_CLEAR_BITS_MASKED, ALD_OP_INCREMENT, ALD_OP_ZERO_SIGN_TEST: op_known = 1'b1;
      default: op_known = 1'b0;
    endcase

    // The answer comes one cycle after setup, so the registers only move at the access edge.
    s_d.pready = psel & ~penable;
    if (psel & ~penable) begin
      s_d.prdata = pwrite ? `ALD_RST_WORD : rd_word;
      s_d.pslverr = ~mapped;
    end
    wr_take = psel & penable & s_q.pready & pwrite & mapped;
    // A control write while the word sequence runs is ignored; the bus spacing keeps it from happening.
    start = wr_take & sel_ctrl & op_known & (s_q.st == ALD_ST_IDLE);

    if (wr_take & sel_dest) begin
      s_d.dest = pwdata[7:0];
    end
    if (wr_take & sel_src) begin
      s_d.src = pwdata[7:0];
    end
    if (wr_take & sel_high) begin
      s_d.high = pwdata[7:0];
    end
    if (wr_take & sel_imm) begin
      s_d.imm = pwdata[7:0];
    end
    if (wr_take & sel_flags) begin
      s_d.sreg = pwdata[7:0];
    end

    case (s_q.st)
      ALD_ST_IDLE: begin
        if (start) begin
          s_d.op = new_op;
          // Every branch writes only the flags it names; the rest stay as they were.
          case (new_op)
            ALD_OP_ADD, ALD_OP_ADD_CARRY: begin
              ar = add8(s_q.dest, s_q.src, (new_op == ALD_OP_ADD_CARRY) & c_in);
              res = ar[7:0];
              s_d.sreg[`ALD_FLAG_C] = ar[9];
              s_d.sreg[`ALD_FLAG_H] = ar[8];
              s_d.sreg[`ALD_FLAG_V] = (s_q.dest[7] & s_q.src[7] & ~res[7]) |
                                       (~s_q.dest[7] & ~s_q.src[7] & res[7]);
              s_d.sreg[`ALD_FLAG_N] = res[7];
              s_d.sreg[`ALD_FLAG_Z] = (res == `ALD_ZERO_BYTE);
              s_d.dest = res;
            end
            ALD_OP_SUB, ALD_OP_SUBTRACT_CONSTANT, ALD_OP_SUBTRACT_WITH_BORROW,
            ALD_OP_SUBTRACT_CONSTANT_WITH_BORROW, ALD_OP_TWOS_COMPLEMENT_FLIP: begin
              if ((new_op == ALD_OP_SUBTRACT_CONSTANT) | (new_op == ALD_OP_SUBTRACT_CONSTANT_WITH_BORROW)) begin
                opnd = s_q.imm;
              end
              if (new_op == ALD_OP_TWOS_COMPLEMENT_FLIP) begin
                ar = sub8(`ALD_ZERO_BYTE, s_q.dest, 1'b0);
                opnd = s_q.dest;
              end else begin
                ar = sub8(s_q.dest, opnd, ((new_op == ALD_OP_SUBTRACT_WITH_BORROW) |
                          (new_op == ALD_OP_SUBTRACT_CONSTANT_WITH_BORROW)) & c_in);
              end
              res = ar[7:0];
              s_d.sreg[`ALD_FLAG_C] = ar[9];
              s_d.sreg[`ALD_FLAG_H] = ar[8];
              if (new_op == ALD_OP_TWOS_COMPLEMENT_FLIP) begin
                s_d.sreg[`ALD_FLAG_V] = (res == `ALD_SIGN_MIN);
              end else begin
                s_d.sreg[`ALD_FLAG_V] = (s_q.dest[7] & ~opnd[7] & ~res[7]) |
                                         (~s_q.dest[7] & opnd[7] & res[7]);
              end
              s_d.sreg[`ALD_FLAG_N] = res[7];
              s_d.sreg[`ALD_FLAG_Z] = (res == `ALD_ZERO_BYTE);
              s_d.dest = res;
            end
            ALD_OP_WORD_ADD_IMMEDIATE, ALD_OP_WORD_SUBTRACT_IMMEDIATE: begin
              // Low byte now, high byte and flags ZCNVS at the second clock.
              if (new_op == ALD_OP_WORD_ADD_IMMEDIATE) begin
                ar = add8(s_q.dest, s_q.imm, 1'b0);
              end else begin
                ar = sub8(s_q.dest, s_q.imm, 1'b0);
              end
              s_d.dest = ar[7:0];
              // The low byte's carry or borrow waits one clock in the state record.
              s_d.lo_carry = ar[9];
              s_d.st = ALD_ST_WORD_HI;
            end
            default: begin
              if ((new_op == ALD_OP_AND) | (new_op == ALD_OP_ZERO_SIGN_TEST)) begin
                res = s_q.dest & ((new_op == ALD_OP_AND) ? s_q.src : s_q.dest);
              end else if (new_op == ALD_OP_AND_CONSTANT) begin
                res = s_q.dest & s_q.imm;
              end else if (new_op == ALD_OP_OR) begin
                res = s_q.dest | s_q.src;
              end else if (new_op == ALD_OP_EXCLUSIVE_OR) begin
                res = s_q.dest ^ s_q.src;
              end else if (new_op == ALD_OP_OR_CONSTANT) begin
                res = s_q.dest | s_q.imm;
              end else if (new_op == ALD_OP_SET_BITS_MASKED) begin
                res = s_q.dest | s_q.imm;
              end else if (new_op == ALD_OP_CLEAR_BITS_MASKED) begin
                res = s_q.dest & (`ALD_ALL_ONES - s_q.imm);
              end else begin
                res = s_q.dest + `ALD_ONE_BYTE;
              end
              // Logic results clear overflow; increment flags a wrap into the sign bit.
              s_d.sreg[`ALD_FLAG_V] = (new_op == ALD_OP_INCREMENT) & (res == `ALD_SIGN_MIN);
              s_d.sreg[`ALD_FLAG_N] = res[7];
              s_d.sreg[`ALD_FLAG_Z] = (res == `ALD_ZERO_BYTE);
              s_d.dest = res;
            end
          endcase
        end
      end
      ALD_ST_WORD_HI: begin
        // The constant is only eight bits wide, so the high byte just absorbs the carry or borrow.
        // Half carry is left alone here because word operations do not name it.
        if (s_q.op == ALD_OP_WORD_ADD_IMMEDIATE) begin
          hres = s_q.high + {7'h00, s_q.lo_carry};
          s_d.sreg[`ALD_FLAG_C] = ~hres[7] & s_q.high[7];
          s_d.sreg[`ALD_FLAG_V] = hres[7] & ~s_q.high[7];
        end else begin
          hres = s_q.high - {7'h00, s_q.lo_carry};
          s_d.sreg[`ALD_FLAG_C] = hres[7] & ~s_q.high[7];
          s_d.sreg[`ALD_FLAG_V] = ~hres[7] & s_q.high[7];
        end
        word = {hres, s_q.dest};
        s_d.sreg[`ALD_FLAG_N] = hres[7];
        s_d.sreg[`ALD_FLAG_S] = hres[7] ^ s_d.sreg[`ALD_FLAG_V];
        s_d.sreg[`ALD_FLAG_Z] = (word == {`ALD_ZERO_BYTE, `ALD_ZERO_BYTE});
        s_d.high = hres;
        s_d.st = ALD_ST_IDLE;
      end
      default: begin
        s_d.st = ALD_ST_IDLE;
      end
    endcase
  end

  // Reset clears every operand and flag, so the first operation after reset sees known values.
  // Only constants are loaded in the reset branch to keep the asynchronous path clean.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q.st <= ALD_ST_IDLE;
      s_q.op <= ALD_OP_ADD;
      s_q.dest <= `ALD_RST_BYTE;
      s_q.src <= `ALD_RST_BYTE;
      s_q.high <= `ALD_RST_BYTE;
      s_q.imm <= `ALD_RST_BYTE;
      s_q.sreg <= `ALD_RST_BYTE;
      s_q.lo_carry <= 1'b0;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= `ALD_RST_WORD;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a plain copy of a state bit, so nothing glitches between edges.
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign status_flags = s_q.sreg;
  assign busy = (s_q.st == ALD_ST_WORD_HI);

endmodule

// file: hw/ald_map.svh
// Register offsets, flag positions, reset values and operand constants of the 8-bit datapath.
// Assumes a 32-bit APB bus with byte addresses on an 8-bit paddr.
`ifndef ALD_MAP_SVH
`define ALD_MAP_SVH

`define ALD_OFF_CTRL 8'h00
`define ALD_OFF_DEST 8'h04
`define ALD_OFF_SRC 8'h08
`define ALD_OFF_HIGH 8'h0C
`define ALD_OFF_IMM 8'h10
`define ALD_OFF_FLAGS 8'h14

`define ALD_CTRL_OP_MSB 4
`define ALD_CTRL_BUSY_BIT 8

`define ALD_FLAG_C 0
`define ALD_FLAG_Z 1
`define ALD_FLAG_N 2
`define ALD_FLAG_V 3
`define ALD_FLAG_S 4
`define ALD_FLAG_H 5

`define ALD_RST_BYTE 8'h00
`define ALD_RST_WORD 32'h0000_0000
`define ALD_ZERO_BYTE 8'h00
`define ALD_ALL_ONES 8'hFF
`define ALD_ONE_BYTE 8'h01
`define ALD_SIGN_MIN 8'h80
`define ALD_NIBBLE_MAX 5'h0F

`endif

// file: hw/ald_pkg.sv
// Types of the 8-bit arithmetic and logic datapath: operation codes, sequencer states and the state record.
// Assumes nothing of its surroundings.
package ald_pkg;

  typedef enum logic [4:0] {
    ALD_OP_ADD = 5'b00000,
    ALD_OP_ADD_CARRY = 5'b00001,
    ALD_OP_WORD_ADD_IMMEDIATE = 5'b00010,
    ALD_OP_SUB = 5'b00011,
    ALD_OP_SUBTRACT_CONSTANT = 5'b00100,
    ALD_OP_SUBTRACT_WITH_BORROW = 5'b00101,
    ALD_OP_SUBTRACT_CONSTANT_WITH_BORROW = 5'b00110,
    ALD_OP_WORD_SUBTRACT_IMMEDIATE = 5'b00111,
    ALD_OP_AND = 5'b01000,
    ALD_OP_AND_CONSTANT = 5'b01001,
    ALD_OP_OR = 5'b01010,
    ALD_OP_OR_CONSTANT = 5'b01011,
    ALD_OP_EXCLUSIVE_OR = 5'b01100,
    ALD_OP_TWOS_COMPLEMENT_FLIP = 5'b01101,
    ALD_OP_SET_BITS_MASKED = 5'b01110,
    ALD_OP_CLEAR_BITS_MASKED = 5'b01111,
    ALD_OP_INCREMENT = 5'b10000,
    ALD_OP_ZERO_SIGN_TEST = 5'b10001
  } ald_op_e;

  typedef enum logic [0:0] {
    ALD_ST_IDLE = 1'b0,
    ALD_ST_WORD_HI = 1'b1
  } ald_state_e;

  typedef struct packed {
    ald_state_e st;
    ald_op_e op;
    logic [7:0] dest;
    logic [7:0] src;
    logic [7:0] high;
    logic [7:0] imm;
    logic [7:0] sreg;
    logic lo_carry;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ald_state_s;

endpackage
